// ===== src/etbt_pkg.sv
// Shared constants for the E1 transmit backplane timing block.
// Assumes a 100 MHz core clock and a byte-wide register port.
package etbt_pkg;
  // ----------------------------------------
  // Register map, one page per link
  // ----------------------------------------
  localparam logic [9:0] LINK_PAGE_SIZE = 10'h100;
  localparam logic [7:0] OFF_REFCLK_CTRL = 8'h3E;
  localparam logic [7:0] OFF_LIU_IND = 8'h3F;
  localparam logic [7:0] OFF_FRM_IND = 8'h40;
  localparam logic [7:0] OFF_LINK_IND = 8'h41;
  localparam logic [7:0] OFF_TB_OPT = 8'h42;
  localparam logic [7:0] OFF_TB_MODE = 8'h43;
  localparam logic [7:0] OFF_TB_TIMESLOT_OFFSET = 8'h44;
  // Own choice: line status register with the loss flag
  localparam logic [7:0] OFF_LINE_STAT = 8'h36;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_FRAME_TYPE = 0;
  localparam int BIT_FRAME_POL = 1;
  localparam int BIT_RATE_SEL = 2;
  localparam int BIT_FRAME_EDGE = 3;
  localparam int BIT_DATA_EDGE = 4;
  localparam int BIT_SUB_MODE = 0;
  localparam int BIT_MUX_MODE = 1;
  localparam int BIT_SHARED_CLK = 2;
  localparam int BIT_CRC_MF = 3;
  localparam int BIT_SIG_MF = 4;
  localparam int BIT_HOLD_LOS = 0;
  localparam int BIT_SYS_IRQ = 0;
  localparam int BIT_LOSS = 0;
  // ----------------------------------------
  // Reset values and frame geometry
  // ----------------------------------------
  localparam logic [7:0] RST_TB_OPT = 8'h00;
  localparam logic [7:0] RST_TB_MODE = 8'h00;
  localparam logic [7:0] RST_TB_TIMESLOT_OFFSET = 8'h00;
  localparam logic [7:0] RST_REFCLK_CTRL = 8'h00;
  localparam logic [7:0] BITS_PER_FRAME_M1 = 8'hFF;
  localparam logic [3:0] CRC_MF_FRAMES_M1 = 4'hF;
  localparam logic [3:0] SIG_MF_FRAMES_M1 = 4'hF;
  localparam logic [6:0] TIMESLOT_OFFSET_MAX_PLAIN = 7'h1F;
  // Master-mode clock divider: half period in core cycles
  localparam int CLK_NS = 10;
  localparam int TXCLK_HALF_NS = 240;
  localparam int TXCLK_HALF_CYC = TXCLK_HALF_NS / CLK_NS;
endpackage

// ===== src/etbt_cfg_if.sv
// Configuration bundle from the register file to the bit timer.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface etbt_cfg_if;
  logic data_edge_select;
  logic frame_edge_select;
  logic clock_rate_select;
  logic frame_polarity;
  logic frame_type;
  logic tx_sub_mode;
  logic mux_mode;
  logic crc_mf;
  logic sig_mf;
  logic [6:0] timeslot_offset;
  logic irq_pending;
  modport regs (output data_edge_select, frame_edge_select, clock_rate_select,
    frame_polarity, frame_type, tx_sub_mode, mux_mode, crc_mf, sig_mf,
    timeslot_offset, input irq_pending);
  modport timer (input data_edge_select, frame_edge_select, clock_rate_select,
    frame_polarity, frame_type, tx_sub_mode, mux_mode, crc_mf, sig_mf,
    timeslot_offset, output irq_pending);
endinterface
`default_nettype wire

// ===== src/etbt_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input; output changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module etbt_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  // ----------------------------------------
  // Stages
  // ----------------------------------------
  // Only s2 reads s1, keeping metastability away from logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/etbt_top.sv
// E1 transmit backplane timing for one link: registers, clock edge
// detection, frame pulse handling and timeslot-aligned bit sampling.
// Assumes the system clock, frame pulse and data are asynchronous pins
// and a much slower link clock (at least four core cycles per half period).
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
//Contract
// - Link copies at 0x100-spaced page offsets
// - Data edge select: 0 falling, 1 rising
// - Frame edge select: 0 falling, 1 rising
// - Rate select 1 means double-speed clock
// - Frame polarity 0 high, 1 low
// - Frame type 0 marks basic frames
// - Frame type 1 marks multiframes, combined form
// - Mux multiframe marking follows first link; code has no cross-link marking, each link keeps its own frame count
// - Master sub-mode: device makes clock, pulse; code drives neither while mux mode is set
// - Timeslot offset separates pulse and frame
// - Signaling aligned per timeslot with data
// - Indication bit shows pending system irq
// - On loss, refclk master or high
// - Loss comes from line loss flag
module etbt_top
  import etbt_pkg::*;
#(
  parameter logic [1:0] LINK_ID = 2'h0
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TX_SYS_CLOCK_IN,
  output logic TX_SYS_CLOCK_OUT,
  output logic TX_SYS_CLOCK_OE_N,
  input wire logic TX_SYS_FRAME_PULSE_IN,
  output logic TX_SYS_FRAME_PULSE_OUT,
  output logic TX_SYS_FRAME_PULSE_OE_N,
  input wire logic TX_SYS_SERIAL_IN,
  input wire logic TX_SYS_SIGNALING_IN,
  input wire logic SIGNAL_LOSS_FLAG,
  input wire logic MASTER_CLOCK,
  input wire logic [7:0] FRAMER_IRQ,
  input wire logic [6:0] LINK_IRQ,
  input wire logic LIU_IRQ,
  input wire logic RX_SYS_IRQ,
  output logic REF_CLOCK_OUT_A,
  output logic REF_CLOCK_OUT_B,
  output logic TX_DATA_BIT,
  output logic TX_SIG_BIT,
  output logic TX_BIT_VALID,
  output logic [4:0] TX_TIMESLOT,
  output logic [2:0] TX_BIT_IN_SLOT,
  output logic TX_FRAME_START
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_a;
  logic rst_n;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  etbt_cfg_if cfg ();
  logic [7:0] opt_reg;
  logic [7:0] mode_reg;
  logic [7:0] timeslot_offset_reg;
  logic [7:0] ref_reg;
  logic loss_s;
  logic mclk_s;
  // Page must match this link; offset picks the register
  wire page_hit = (ADDR[9:8] == LINK_ID);
  wire [7:0] offs = ADDR[7:0];
  wire wr_opt = WR && page_hit && (offs == OFF_TB_OPT);
  wire wr_mode = WR && page_hit && (offs == OFF_TB_MODE);
  wire wr_timeslot_offset = WR && page_hit && (offs == OFF_TB_TIMESLOT_OFFSET);
  wire wr_ref = WR && page_hit && (offs == OFF_REFCLK_CTRL);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      opt_reg <= RST_TB_OPT;
      mode_reg <= RST_TB_MODE;
      timeslot_offset_reg <= RST_TB_TIMESLOT_OFFSET;
      ref_reg <= RST_REFCLK_CTRL;
    end else begin
      if (wr_opt) opt_reg <= {3'h0, WDATA[4:0]};
      if (wr_mode) mode_reg <= {3'h0, WDATA[4:0]};
      if (wr_timeslot_offset) timeslot_offset_reg <= {1'b0, WDATA[6:0]};
      if (wr_ref) ref_reg <= {7'h00, WDATA[0]};
    end
  end

  // Field split; range of the offset is software's duty
  assign cfg.data_edge_select = opt_reg[BIT_DATA_EDGE];
  assign cfg.frame_edge_select = opt_reg[BIT_FRAME_EDGE];
  assign cfg.clock_rate_select = opt_reg[BIT_RATE_SEL];
  assign cfg.frame_polarity = opt_reg[BIT_FRAME_POL];
  assign cfg.frame_type = opt_reg[BIT_FRAME_TYPE];
  assign cfg.tx_sub_mode = mode_reg[BIT_SUB_MODE];
  assign cfg.mux_mode = mode_reg[BIT_MUX_MODE];
  assign cfg.crc_mf = mode_reg[BIT_CRC_MF];
  assign cfg.sig_mf = mode_reg[BIT_SIG_MF];
  assign cfg.timeslot_offset = timeslot_offset_reg[6:0];

  // Read mux; unmapped offsets and foreign pages read zero
  logic sys_irq;
  wire [7:0] link_ind = {LINK_IRQ, sys_irq};
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (RD && page_hit) begin
      case (offs)
        OFF_REFCLK_CTRL: next_rdata = ref_reg;
        OFF_LIU_IND: next_rdata = {7'h00, LIU_IRQ};
        OFF_FRM_IND: next_rdata = {2'h0, FRAMER_IRQ[5:0]};
        OFF_LINK_IND: next_rdata = link_ind;
        OFF_TB_OPT: next_rdata = opt_reg;
        OFF_TB_MODE: next_rdata = mode_reg;
        OFF_TB_TIMESLOT_OFFSET: next_rdata = timeslot_offset_reg;
        OFF_LINE_STAT: next_rdata = {7'h00, loss_s};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= 8'h00;
    else RDATA <= next_rdata;
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic clk_pin_s;
  logic fp_pin_s;
  logic sd_s;
  logic sig_s;
  etbt_sync u_sync_clk (.clk(CLK), .rst_n(rst_n), .din(TX_SYS_CLOCK_IN), .dout(clk_pin_s));
  etbt_sync u_sync_fp (.clk(CLK), .rst_n(rst_n), .din(TX_SYS_FRAME_PULSE_IN), .dout(fp_pin_s));
  etbt_sync u_sync_sd (.clk(CLK), .rst_n(rst_n), .din(TX_SYS_SERIAL_IN), .dout(sd_s));
  etbt_sync u_sync_sig (.clk(CLK), .rst_n(rst_n), .din(TX_SYS_SIGNALING_IN), .dout(sig_s));
  etbt_sync u_sync_los (.clk(CLK), .rst_n(rst_n), .din(SIGNAL_LOSS_FLAG), .dout(loss_s));
  etbt_sync u_sync_mclk (.clk(CLK), .rst_n(rst_n), .din(MASTER_CLOCK), .dout(mclk_s));

  // ----------------------------------------
  // Bit timer on the chosen link clock edges
  // ----------------------------------------
  logic own_clk;
  logic own_fp;
  logic own_fp_oe;
  etbt_timer u_timer (
    .clk(CLK),
    .rst_n(rst_n),
    .cfg(cfg.timer),
    .link_clk_pin(clk_pin_s),
    .frame_pin(fp_pin_s),
    .data_pin(sd_s),
    .sig_pin(sig_s),
    .rx_irq(RX_SYS_IRQ),
    .own_clk(own_clk),
    .own_fp(own_fp),
    .own_fp_drive(own_fp_oe),
    .data_bit(TX_DATA_BIT),
    .sig_bit(TX_SIG_BIT),
    .bit_valid(TX_BIT_VALID),
    .timeslot(TX_TIMESLOT),
    .bit_in_slot(TX_BIT_IN_SLOT),
    .frame_start(TX_FRAME_START)
  );
  assign sys_irq = cfg.irq_pending;

  // ----------------------------------------
  // Pin drivers and reference clock outputs
  // ----------------------------------------
  // Master sub-mode outside mux mode drives clock and pulse out
  wire drive_clk = !cfg.tx_sub_mode && !cfg.mux_mode;
  wire ref_level = (loss_s && ref_reg[BIT_HOLD_LOS]) ? 1'b1 : mclk_s;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_SYS_CLOCK_OUT <= 1'b0;
      TX_SYS_CLOCK_OE_N <= 1'b1;
      TX_SYS_FRAME_PULSE_OUT <= 1'b0;
      TX_SYS_FRAME_PULSE_OE_N <= 1'b1;
      REF_CLOCK_OUT_A <= 1'b0;
      REF_CLOCK_OUT_B <= 1'b0;
    end else begin
      TX_SYS_CLOCK_OUT <= own_clk;
      TX_SYS_CLOCK_OE_N <= !drive_clk;
      TX_SYS_FRAME_PULSE_OUT <= own_fp;
      TX_SYS_FRAME_PULSE_OE_N <= !(drive_clk && own_fp_oe);
      REF_CLOCK_OUT_A <= ref_level;
      REF_CLOCK_OUT_B <= ref_level;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ref_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (loss_s && ref_reg[BIT_HOLD_LOS]) |=> REF_CLOCK_OUT_A)
    else $error("reference clock not held high on loss");
  ref_pass_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !loss_s |=> (REF_CLOCK_OUT_B == $past(mclk_s)))
    else $error("reference clock not following master clock");
  irq_ind_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (RD && page_hit && offs == OFF_LINK_IND) |=> (RDATA[0] == $past(sys_irq)))
    else $error("system interface indication wrong");
  page_sel_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (WR && !page_hit) |=> $stable(opt_reg))
    else $error("foreign page write changed options");
  clk_drive_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (!cfg.tx_sub_mode && !cfg.mux_mode) |=> !TX_SYS_CLOCK_OE_N)
    else $error("master mode did not drive clock");
  slave_hiz_a: assert property (@(posedge CLK) disable iff (!rst_n)
    cfg.tx_sub_mode |=> (TX_SYS_CLOCK_OE_N && TX_SYS_FRAME_PULSE_OE_N))
    else $error("slave mode drove clock or pulse");
endmodule
`default_nettype wire

// ===== src/etbt_timer.sv
// Link clock edge detection, frame pulse decode, bit and timeslot counting.
// Assumes synchronised pins on the core clock.
`timescale 1ns/1ns
`default_nettype none
module etbt_timer
  import etbt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  etbt_cfg_if.timer cfg,
  input wire logic link_clk_pin,
  input wire logic frame_pin,
  input wire logic data_pin,
  input wire logic sig_pin,
  input wire logic rx_irq,
  output logic own_clk,
  output logic own_fp,
  output logic own_fp_drive,
  output logic data_bit,
  output logic sig_bit,
  output logic bit_valid,
  output logic [4:0] timeslot,
  output logic [2:0] bit_in_slot,
  output logic frame_start
);
  // ----------------------------------------
  // Clock source: own divider or the pin
  // ----------------------------------------
  logic [7:0] div_cnt;
  logic clk_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      own_clk <= 1'b0;
    end else if (div_cnt == 8'(TXCLK_HALF_CYC - 1)) begin
      div_cnt <= 8'h00;
      own_clk <= !own_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  wire master = !cfg.tx_sub_mode && !cfg.mux_mode;
  wire lclk = master ? own_clk : link_clk_pin;
  wire rise = lclk && !clk_prev;
  wire fall = !lclk && clk_prev;
  wire data_edge = cfg.data_edge_select ? rise : fall;
  wire frame_edge = cfg.frame_edge_select ? rise : fall;

  // ----------------------------------------
  // Frame pulse decode
  // ----------------------------------------
  logic fp_prev;
  logic half;
  wire fp_act = frame_pin ^ cfg.frame_polarity;
  // Only the asserting edge is a start, so a pulse held over both
  // edges of a double-speed bit, or a combined multiframe level, loads once
  wire fp_seen = frame_edge && fp_act && !fp_prev;
  // Double speed takes every second edge; the pulse edge is the first
  wire bit_tick = data_edge && (!cfg.clock_rate_select || (half && !fp_seen));

  // ----------------------------------------
  // Bit position counter
  // ----------------------------------------
  logic [7:0] bitpos;
  logic [3:0] frame_no;
  logic [7:0] start_pos;
  logic synced;
  // Pulse leads the frame by the offset in timeslots
  assign start_pos = 8'h00 - {cfg.timeslot_offset[4:0], 3'h0};
  // The bit that carries the pulse already sits at the loaded position
  wire [7:0] cur_pos = fp_seen ? start_pos : bitpos;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'b0;
      fp_prev <= 1'b0;
      half <= 1'b0;
      bitpos <= 8'h00;
      frame_no <= 4'h0;
      synced <= 1'b0;
    end else begin
      clk_prev <= lclk;
      if (frame_edge) fp_prev <= fp_act;
      if (fp_seen) begin
        bitpos <= cfg.clock_rate_select ? start_pos : start_pos + 8'h01;
        half <= cfg.clock_rate_select;
        frame_no <= 4'h0;
        synced <= 1'b1;
      end else if (data_edge) begin
        half <= cfg.clock_rate_select ? !half : 1'b0;
        if (bit_tick) begin
          bitpos <= bitpos + 8'h01;
          if (bitpos == BITS_PER_FRAME_M1) frame_no <= frame_no + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Sampled outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_bit <= 1'b0;
      sig_bit <= 1'b0;
      bit_valid <= 1'b0;
      timeslot <= 5'h00;
      bit_in_slot <= 3'h0;
      frame_start <= 1'b0;
      own_fp <= 1'b0;
      own_fp_drive <= 1'b0;
    end else begin
      bit_valid <= bit_tick && (synced || fp_seen);
      frame_start <= bit_tick && (synced || fp_seen) && (cur_pos == 8'h00);
      if (bit_tick) begin
        data_bit <= data_pin;
        sig_bit <= sig_pin;
        timeslot <= cur_pos[7:3];
        bit_in_slot <= cur_pos[2:0];
      end
      own_fp_drive <= master;
      // Master pulse at frame bit 0, or multiframe start with frame type
      if (frame_edge) own_fp <= cfg.frame_polarity ^ ((bitpos == 8'h00) &&
        (!cfg.frame_type || frame_no == 4'h0));
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg.irq_pending <= 1'b0;
    else cfg.irq_pending <= rx_irq;
  end

  slot_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (data_edge && cfg.clock_rate_select && !half && !fp_seen) |=> $stable(bitpos))
    else $error("double speed advanced on first edge");
  pulse_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    fp_seen |=> (bitpos == $past(start_pos + {7'h00, !cfg.clock_rate_select})))
    else $error("pulse did not load offset position");
endmodule
`default_nettype wire

// ===== verif/etbt_sys_model.sv
// System-side transmit framer model: link clock, frame pulse, data, signaling.
// Assumes the bench sets the config inputs before calling send.
`timescale 1ns/1ns
`default_nettype none
module etbt_sys_model (
  input wire logic de,
  input wire logic rate,
  input wire logic pol,
  input wire logic [4:0] off,
  input wire logic [255:0] dpat,
  input wire logic [255:0] spat,
  output logic sclk,
  output logic fp,
  output logic sd,
  output logic sig
);
  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    fp = 1'b0;
    sd = 1'b0;
    sig = 1'b0;
  end
  // Clock stands still between calls of send; data moves on the idle edge,
  // a full half period away from the sampling edge
  task automatic send(input int nfr);
    int p;
    sclk = ~de;
    fp = pol;
    #400;
    for (int q = 0; q < nfr * 256; q++) begin
      p = (q - 8 * off) & 255;
      sd = dpat[p];
      sig = spat[p];
      fp = ((q % 256) == 0) ^ pol;
      repeat (rate ? 2 : 1) begin
        #40 sclk = de;
        #40 sclk = ~de;
      end
    end
    // Released lines must not keep the last value
    fp = pol;
    sd = ~sd;
    sig = ~sig;
  endtask
endmodule
`default_nettype wire

// ===== verif/e1_transmit_backplane_timing_test.sv
// Self-checking bench for the transmit backplane timing block.
// Assumes the design package and the framer model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module e1_transmit_backplane_timing_test;
  import etbt_pkg::*;
  logic clk, arst_n, wr, rd, loss, mclk, liu_irq, rx_irq;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, frm_irq;
  logic [6:0] link_irq;
  logic clk_out, clk_oe_n, fp_out, fp_oe_n, ref_a, ref_b;
  logic dbit, sbit, bvalid, fstart, de, rate, pol;
  logic [4:0] ts, off;
  logic [2:0] bis;
  logic [255:0] dpat, spat;
  logic sclk, sfp, ssd, ssig, clk_w, fp_w, rd_d, armed;
  logic [7:0] rd_q[$];
  logic [9:0] bit_q[$];
  int failures, n_checks;

  // Shared pins: the device drives them only while its enable is low
  assign clk_w = clk_oe_n ? sclk : clk_out;
  assign fp_w = fp_oe_n ? sfp : fp_out;

  etbt_top dut_u (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TX_SYS_CLOCK_IN(clk_w), .TX_SYS_CLOCK_OUT(clk_out),
    .TX_SYS_CLOCK_OE_N(clk_oe_n), .TX_SYS_FRAME_PULSE_IN(fp_w),
    .TX_SYS_FRAME_PULSE_OUT(fp_out), .TX_SYS_FRAME_PULSE_OE_N(fp_oe_n),
    .TX_SYS_SERIAL_IN(ssd), .TX_SYS_SIGNALING_IN(ssig), .SIGNAL_LOSS_FLAG(loss),
    .MASTER_CLOCK(mclk), .FRAMER_IRQ(frm_irq), .LINK_IRQ(link_irq), .LIU_IRQ(liu_irq),
    .RX_SYS_IRQ(rx_irq), .REF_CLOCK_OUT_A(ref_a), .REF_CLOCK_OUT_B(ref_b),
    .TX_DATA_BIT(dbit), .TX_SIG_BIT(sbit), .TX_BIT_VALID(bvalid), .TX_TIMESLOT(ts),
    .TX_BIT_IN_SLOT(bis), .TX_FRAME_START(fstart));

  etbt_sys_model sys_u (.de(de), .rate(rate), .pol(pol), .off(off), .dpat(dpat),
    .spat(spat), .sclk(sclk), .fp(sfp), .sd(ssd), .sig(ssig));

  // ----------------------------------------
  // Clocks, compare and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Slow master clock for the reference outputs
  initial forever begin
    repeat (4) @(posedge clk);
    mclk <= ~mclk;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic finish_test;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watcher: read data one cycle after the strobe, bits once a frame starts
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) check({2'h0, rdata}, {2'h0, rd_q.pop_front()}, "read data");
    if (bvalid && (armed || fstart) && bit_q.size() > 0) begin
      armed <= 1'b1;
      check({ts, bis, dbit, sbit}, bit_q[0], "bit stream");
      check({9'h0, fstart}, {9'h0, bit_q[0][9:2] == 8'h00}, "frame start");
      bit_q.delete(0);
    end
  end

  // ----------------------------------------
  // Bus and scenario tasks
  // ----------------------------------------
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic ref_probe(input logic held);
    int hi, tog;
    logic last;
    hi = 0;
    tog = 0;
    last = ref_a;
    repeat (40) begin
      @(posedge clk);
      hi += int'(ref_a === 1'b1 && ref_b === 1'b1);
      tog += int'(ref_a !== last);
      last = ref_a;
    end
    check({9'h0, held ? hi == 40 : tog >= 4}, 10'h1, "ref clock");
  endtask

  // Counts core cycles until the next rise of the device's own link clock
  task automatic wait_rise(output int n);
    logic last;
    n = 0;
    last = clk_out;
    while (n < 200 && !(clk_out === 1'b1 && last === 1'b0)) begin
      last = clk_out;
      @(posedge clk);
      n++;
    end
  endtask

  // Slave-mode frames: expected bits are noted before the framer starts
  task automatic stream(input logic [7:0] opt, input logic [4:0] o, input int nfr);
    int n;
    reg_wr({2'h0, OFF_TB_OPT}, opt);
    reg_wr({2'h0, OFF_TB_TIMESLOT_OFFSET}, {3'h0, o});
    reg_wr({2'h0, OFF_TB_MODE}, 8'h01);
    de = opt[BIT_DATA_EDGE];
    rate = opt[BIT_RATE_SEL];
    pol = opt[BIT_FRAME_POL];
    off = o;
    for (int i = 0; i < 8; i++) begin
      dpat[i*32+:32] = $urandom;
      spat[i*32+:32] = $urandom;
    end
    armed = 1'b0;
    repeat (20) @(posedge clk);
    check({8'h0, clk_oe_n, fp_oe_n}, 10'h3, "slave release");
    for (int k = 0; k < nfr * 256 - 8 * o; k++) begin
      bit_q.push_back({8'(k), dpat[k & 255], spat[k & 255]});
    end
    sys_u.send(nfr);
    n = 0;
    while (bit_q.size() > 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(10'(bit_q.size()), 10'h0, "bits missing");
    bit_q.delete();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    int n;
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 10'h000;
    wdata = 8'h00;
    loss = 1'b0;
    mclk = 1'b0;
    frm_irq = 8'h00;
    link_irq = 7'h00;
    liu_irq = 1'b0;
    rx_irq = 1'b0;
    de = 1'b1;
    rate = 1'b0;
    pol = 1'b0;
    off = 5'h00;
    dpat = '0;
    spat = '0;
    armed = 1'b0;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'h6c20a21f));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd({2'h0, OFF_TB_OPT}, RST_TB_OPT);
    reg_rd({2'h0, OFF_TB_MODE}, RST_TB_MODE);
    reg_rd({2'h0, OFF_TB_TIMESLOT_OFFSET}, RST_TB_TIMESLOT_OFFSET);
    reg_rd({2'h0, OFF_REFCLK_CTRL}, RST_REFCLK_CTRL);
    // Readback, a foreign link page and an unmapped offset
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & 8'h1F;
      reg_wr({2'h0, OFF_TB_OPT}, v);
      reg_wr({2'h1, OFF_TB_OPT}, ~v);
      reg_rd({2'h0, OFF_TB_OPT}, v);
      reg_rd({2'h1, OFF_TB_OPT}, 8'h00);
      v = 8'($urandom) & 8'h7F;
      reg_wr({2'h0, OFF_TB_TIMESLOT_OFFSET}, v);
      reg_rd({2'h0, OFF_TB_TIMESLOT_OFFSET}, v);
    end
    reg_rd(10'h050, 8'h00);
    // Indication registers are read-only levels
    frm_irq <= 8'($urandom) & 8'h3F;
    link_irq <= 7'($urandom);
    rx_irq <= 1'b1;
    liu_irq <= 1'b1;
    repeat (5) @(posedge clk);
    reg_wr({2'h0, OFF_LINK_IND}, 8'h00);
    reg_rd({2'h0, OFF_FRM_IND}, frm_irq);
    reg_rd({2'h0, OFF_LINK_IND}, {link_irq, 1'b1});
    rx_irq <= 1'b0;
    repeat (5) @(posedge clk);
    reg_rd({2'h0, OFF_LINK_IND}, {link_irq, 1'b0});
    // Reference outputs under loss, with and without hold
    loss <= 1'b1;
    reg_wr({2'h0, OFF_REFCLK_CTRL}, 8'h01);
    repeat (6) @(posedge clk);
    reg_rd({2'h0, OFF_LINE_STAT}, 8'h01);
    ref_probe(1'b1);
    reg_wr({2'h0, OFF_REFCLK_CTRL}, 8'h00);
    repeat (6) @(posedge clk);
    ref_probe(1'b0);
    loss <= 1'b0;
    reg_wr({2'h0, OFF_REFCLK_CTRL}, 8'h01);
    repeat (6) @(posedge clk);
    ref_probe(1'b0);
    // Master sub-mode: device drives clock and pulse at its own rate
    reg_wr({2'h0, OFF_TB_MODE}, 8'h00);
    repeat (4) @(posedge clk);
    check({8'h0, clk_oe_n, fp_oe_n}, 10'h0, "master drive");
    wait_rise(n);
    wait_rise(n);
    check(10'(n), 10'(2 * TXCLK_HALF_CYC), "master period");
    // Slave streams: edges, polarity, offsets and double rate
    stream(8'h18, 5'd0, 2);
    stream(8'h02, 5'd5, 2);
    stream(8'h1C, 5'd31, 2);
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #600000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
